// ### common/irq_wake_defines.vh
// Constants for the interrupt entry and low-power wake controller
`ifndef IRQ_WAKE_DEFINES_VH
`define IRQ_WAKE_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_IOC 8'hc8
`define IDX_TSC 8'hd4
`define IDX_CONV 8'hd1
`define IDX_RLD 8'hd5
`define IDX_SER 8'he2
`define IDX_STAT 8'hf0

// Option register fields and reset value
`define IOC_RESET 8'h00
`define IOC_LES 6
`define IOC_POL 5
`define IOC_GEN 4

// Enable bit positions inside the peripheral control words
`define TSC_ETI 4
`define CONV_EAI 4
`define RLD_RELOAD_OVERFLOW_IRQ_ENABLE 0
`define RLD_COMPARE_IRQ_ENABLE 1
`define RLD_EIE 2
`define SER_SERIAL_IRQ_ENABLE 4

// Vector addresses in program space
`define VEC_NMI 12'hffc
`define VEC_1 12'hff6
`define VEC_2 12'hff4
`define VEC_3 12'hff2
`define VEC_4 12'hff0

// Flag set / core mode encodings
`define MODE_NORMAL 2'h0
`define MODE_INT 2'h1
`define MODE_NMI 2'h2

// Default oscillator settling count after a stop wake
`define STAB_DEFAULT 16'h0400

`endif

// ### dv/core_model.sv
// Core stand-in: ends one instruction per running cycle
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic core_halt,
    output logic instr_end,
    output logic [11:0] pc_next
);
    // Instruction ends stop while the core is halted
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_end <= 1'b0;
            pc_next <= 12'h000;
        end else begin
            instr_end <= !core_halt;
            pc_next <= pc_next + 12'h001;
        end
    end
endmodule // core_model
`default_nettype wire

// ### dv/irq_wake_chk.sv
// Checker for interrupt entry, return, bus and wake timing
`timescale 1ns/1ns
`default_nettype none
`include "irq_wake_defines.vh"
module irq_wake_chk #(
    parameter STAB_CYCLES = `STAB_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic return_from_interrupt_exec,
    input wire logic stop_exec,
    input wire logic watchdog_active,
    input wire logic irq_entry,
    input wire logic [11:0] vector_pc,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [1:0] flag_set,
    input wire logic core_halt,
    input wire logic osc_run,
    input wire logic core_resume
);
    // Settling span handed down from the design
    localparam int SD = STAB_CYCLES;
    logic osc_q; // Oscillator run level one cycle back
    logic in_stab; // Inside a stop-wake settling span
    int stab_cnt; // Halted cycles counted in that span
    // Counts halted cycles after the oscillator restarts
    always @(posedge clk) begin
        osc_q <= osc_run;
        if (rst) begin
            in_stab <= 1'b0;
            stab_cnt <= 0;
        end else if (osc_run && !osc_q) begin
            in_stab <= 1'b1;
            stab_cnt <= 0;
        end else if (in_stab && core_halt) begin
            stab_cnt <= stab_cnt + 1;
        end else begin
            in_stab <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_push_entry: assert property (irq_entry |-> stack_push && !core_resume)
        else $error("entry without stack push");
    a_push_only: assert property (stack_push |-> irq_entry)
        else $error("stack push without entry");
    a_nmi_vec: assert property (irq_entry && flag_set == `MODE_NMI |-> vector_pc == `VEC_NMI)
        else $error("nmi entry with wrong vector");
    a_int_vec: assert property (irq_entry && flag_set == `MODE_INT |->
        vector_pc != `VEC_NMI && $past(flag_set) == `MODE_NORMAL)
        else $error("maskable entry nested or misvectored");
    a_nmi_once: assert property (irq_entry |-> $past(flag_set) != `MODE_NMI)
        else $error("entry taken in nmi mode");
    a_pop_return_from_interrupt: assert property (return_from_interrupt_exec |=> stack_pop)
        else $error("return without stack pop");
    a_pop_cause: assert property (stack_pop |-> $past(return_from_interrupt_exec))
        else $error("stack pop without return");
    a_bus_wait: assert property ((read || write) && waitrequest |=>
        !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait state");
    a_opt_read: assert property (read && !waitrequest && address == 10'h320
        |-> readdata == 32'h0)
        else $error("option register readable");
    a_stop_wd: assert property (stop_exec && watchdog_active |=> osc_run)
        else $error("stop honoured under watchdog");
    a_osc_cause: assert property ($fell(osc_run) |->
        $past(stop_exec) && !$past(watchdog_active))
        else $error("oscillator stopped without stop");
    a_stab_wait: assert property (in_stab |->
        (core_halt ? stab_cnt < SD : stab_cnt == SD))
        else $error("settling delay wrong");
    a_halt_wake: assert property ($fell(core_halt) |-> irq_entry || core_resume)
        else $error("halt left without entry or resume");
    // Main scenarios reached
    cover property (irq_entry && flag_set == `MODE_NMI);
    cover property ($rose(osc_run));
    cover property (core_resume);
endmodule // irq_wake_chk
bind irq_wake_ctrl irq_wake_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
    .clk, .rst, .address, .read, .write, .readdata, .waitrequest,
    .return_from_interrupt_exec, .stop_exec, .watchdog_active, .irq_entry, .vector_pc,
    .stack_push, .stack_pop, .flag_set, .core_halt, .osc_run, .core_resume
);
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the interrupt entry and wake controller
`timescale 1ns/1ns
`default_nettype none
`include "irq_wake_defines.vh"
module tb_top;
    logic clk, rst, read, write, return_from_interrupt_exec, wait_exec, stop_exec, wd;
    logic tz, ro, sd, cd, nmi_n, pab_n;
    logic [9:0] address;
    logic [31:0] writedata, q;
    int err_count, num_checks;
    wire [31:0] readdata;
    wire [11:0] vector_pc, pc_next, push_pc;
    wire [1:0] flag_set;
    wire waitrequest, irq_entry, stack_push, stack_pop, core_halt;
    wire osc_run, core_resume, instr_end;
    irq_wake_ctrl #(.STAB_CYCLES(4)) i_dut (
        .clk, .rst, .address, .read, .write, .writedata,
        .byteenable(4'hf), .readdata, .waitrequest, .instr_end,
        .return_from_interrupt_exec, .wait_exec, .stop_exec, .pc_next,
        .watchdog_active(wd), .irq_entry, .vector_pc, .stack_push,
        .push_pc, .stack_pop, .flag_set, .core_halt, .osc_run,
        .core_resume, .timer_zero_flag(tz), .conv_done_flag(cd),
        .reload_overflow_flag(ro), .compare_match_flag(1'b0),
        .input_edge_flag(1'b0), .serial_done_flag(sd), .nmi_n,
        .port_ab_n(pab_n), .port_c(1'b0)
    );
    core_model i_core (.clk, .rst, .core_halt, .instr_end, .pc_next);
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Counts one comparison; reports a difference
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // Prints counts and verdict, then stops
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One bus transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            n++;
            @(posedge clk);
        end
        chk("bus wait", n, 1);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    // One-cycle core strobe: 0 return, 1 wait, 2 stop
    task automatic op(input int k);
        return_from_interrupt_exec <= (k == 0);
        wait_exec <= (k == 1);
        stop_exec <= (k == 2);
        @(posedge clk);
        return_from_interrupt_exec <= 1'b0;
        wait_exec <= 1'b0;
        stop_exec <= 1'b0;
        @(negedge clk);
    endtask
    // Return from a routine and check the restored set
    task automatic rtn(input logic [1:0] f);
        op(0);
        chk("pop", stack_pop, 1);
        chk("flags", flag_set, f);
        @(posedge clk);
    endtask
    // Waits for an entry (e=1) or a resume (e=0)
    task automatic hit(input logic e, input logic [11:0] v,
                       input logic [1:0] f);
        int n;
        n = 0;
        @(negedge clk);
        while ((e ? irq_entry : core_resume) !== 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        chk("wake", e ? irq_entry : core_resume, 1);
        chk("flags", flag_set, f);
        if (e) begin
            chk("vector", vector_pc, v);
            chk("push", push_pc, 12'(pc_next - 12'h001));
        end
        @(posedge clk);
    endtask
    // No entry for c cycles; halt level as given
    task automatic idle(input int c, input logic h);
        logic seen;
        seen = 1'b0;
        repeat (c) begin
            @(negedge clk);
            seen = seen | irq_entry;
        end
        chk("entry", seen, 0);
        chk("halt", core_halt, h);
        @(posedge clk);
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #50000;
        err_count++;
        test_done;
    end
    initial begin
        {rst, read, write, return_from_interrupt_exec, wait_exec, stop_exec, wd} = 7'h40;
        {tz, ro, sd, cd, nmi_n, pab_n} = 6'h03;
        address = 10'h000;
        writedata = 32'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("flags", flag_set, `MODE_NORMAL);
        chk("osc", osc_run, 1);
        @(posedge clk);
        bus(1, 10'h320, 32'h70, q);
        bus(0, 10'h320, 0, q);
        chk("option", q, 0);
        bus(0, 10'h004, 0, q);
        chk("unmapped", q, 0);
        $display("test regs done");
        tz <= 1'b1;
        bus(1, 10'h320, 32'h10, q);
        idle(8, 0);
        bus(1, 10'h350, 32'h10, q);
        hit(1, `VEC_4, `MODE_INT);
        tz <= 1'b0;
        sd <= 1'b1;
        bus(1, 10'h388, 32'h10, q);
        idle(6, 0);
        nmi_n <= 1'b0;
        hit(1, `VEC_NMI, `MODE_NMI);
        nmi_n <= 1'b1;
        rtn(`MODE_INT);
        rtn(`MODE_NORMAL);
        hit(1, `VEC_2, `MODE_INT);
        sd <= 1'b0;
        ro <= 1'b1;
        pab_n <= 1'b0;
        bus(1, 10'h354, 32'h01, q);
        rtn(`MODE_NORMAL);
        hit(1, `VEC_1, `MODE_INT);
        pab_n <= 1'b1;
        rtn(`MODE_NORMAL);
        hit(1, `VEC_3, `MODE_INT);
        ro <= 1'b0;
        rtn(`MODE_NORMAL);
        cd <= 1'b1;
        idle(4, 0);
        bus(1, 10'h344, 32'h10, q);
        hit(1, `VEC_4, `MODE_INT);
        cd <= 1'b0;
        rtn(`MODE_NORMAL);
        $display("test entry done");
        bus(1, 10'h320, 32'h00, q);
        tz <= 1'b1;
        idle(6, 0);
        nmi_n <= 1'b0;
        hit(1, `VEC_NMI, `MODE_NMI);
        nmi_n <= 1'b1;
        tz <= 1'b0;
        rtn(`MODE_NORMAL);
        op(1);
        chk("halt", core_halt, 1);
        @(posedge clk);
        nmi_n <= 1'b0;
        idle(8, 1);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        nmi_n <= 1'b1;
        @(negedge clk);
        chk("halt", core_halt, 0);
        chk("flags", flag_set, `MODE_NORMAL);
        @(posedge clk);
        $display("test mask done");
        bus(1, 10'h320, 32'h10, q);
        bus(1, 10'h350, 32'h10, q);
        op(1);
        chk("halt", core_halt, 1);
        @(posedge clk);
        tz <= 1'b1;
        hit(1, `VEC_4, `MODE_INT);
        op(1);
        chk("halt", core_halt, 0);
        @(posedge clk);
        tz <= 1'b0;
        op(1);
        @(posedge clk);
        nmi_n <= 1'b0;
        hit(1, `VEC_NMI, `MODE_NMI);
        nmi_n <= 1'b1;
        rtn(`MODE_INT);
        op(1);
        @(posedge clk);
        tz <= 1'b1;
        hit(0, 0, `MODE_INT);
        tz <= 1'b0;
        rtn(`MODE_NORMAL);
        wd <= 1'b1;
        op(2);
        chk("osc", osc_run, 1);
        chk("halt", core_halt, 1);
        @(posedge clk);
        wd <= 1'b0;
        nmi_n <= 1'b0;
        hit(1, `VEC_NMI, `MODE_NMI);
        nmi_n <= 1'b1;
        op(1);
        @(posedge clk);
        tz <= 1'b1;
        hit(0, 0, `MODE_NMI);
        tz <= 1'b0;
        rtn(`MODE_NORMAL);
        op(2);
        chk("osc", osc_run, 0);
        @(posedge clk);
        tz <= 1'b1;
        idle(8, 1);
        tz <= 1'b0;
        nmi_n <= 1'b0;
        hit(1, `VEC_NMI, `MODE_NMI);
        nmi_n <= 1'b1;
        rtn(`MODE_NORMAL);
        $display("test sleep done");
        test_done;
    end
endmodule // tb_top
`default_nettype wire

// ### rtl/irq_wake_ctrl.v
// Interrupt entry, return and low-power wake sequencing with Avalon slave
`timescale 1ns/1ns
`default_nettype none
`include "irq_wake_defines.vh"

// Summary of operation
// - Entry swaps flags to interrupt or NMI set
// - Entry pushes PC then loads vector address
// - Maskable lines blocked while servicing; NMI live
// - Entry clears serviced source's first latch
// - Return restores prior flag set, pops PC
// - Global enable clear masks all but NMI
// - Conversion done requests vector 4 if enabled
// - Reload timer flags request vector 3, gated
// - Serial done requests vector 2 if enabled
// - Wait halts execution; clock and peripherals run
// - Wait wake resumes with no settling delay
// - Reset during wait runs ordinary reset
// - Stop halts oscillator; wakes on external/reset
// - Stop wake waits for oscillator settling
// - Main-routine sleep: service first, then continue
// - NMI-routine sleep: resume only, stay NMI
// - Maskable-routine sleep, maskable wake: resume routine
// - Maskable-routine sleep, NMI wake: NMI first
// - Active watchdog turns stop into wait
// - Global enable clear: NMI cannot wake
// - Sleep skipped when enabled request pending
// - Lines sampled at each instruction end
// - Fixed priority vector 1 to 4, no nesting
// - Option register write-only, reset zero, fields
// - NMI falling edge latched, cleared on entry
module irq_wake_ctrl #(
    parameter STAB_CYCLES = `STAB_DEFAULT // Oscillator settling cycles
) (
    input wire clk,
    input wire rst,
    // Avalon-MM slave
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    // Core side, same clock
    input wire instr_end,
    input wire return_from_interrupt_exec,
    input wire wait_exec,
    input wire stop_exec,
    input wire [11:0] pc_next,
    input wire watchdog_active,
    output reg irq_entry,
    output reg [11:0] vector_pc,
    output reg stack_push,
    output reg [11:0] push_pc,
    output reg stack_pop,
    output reg [1:0] flag_set,
    output reg core_halt,
    output reg osc_run,
    output reg core_resume,
    // Peripheral flags, same clock
    input wire timer_zero_flag,
    input wire conv_done_flag,
    input wire reload_overflow_flag,
    input wire compare_match_flag,
    input wire input_edge_flag,
    input wire serial_done_flag,
    // External pins, asynchronous
    input wire nmi_n,
    input wire port_ab_n,
    input wire port_c
);

    // Low-power states
    localparam ST_RUN = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_STOP = 2'h2;
    localparam ST_STAB = 2'h3;

    reg [7:0] ioc_q; // Option register, write-only
    reg [7:0] tsc_q; // Timer control enables
    reg [7:0] conv_q; // Converter control enables
    reg [7:0] rld_q; // Reload timer mode enables
    reg [7:0] ser_q; // Serial mode enables
    reg [2:0] nmi_sy_q; // Sync pair plus edge history
    reg [2:0] ab_sy_q;
    reg [2:0] c_sy_q;
    reg nmi_lat_q; // NMI edge latch
    reg v1_first_q; // Vector 1 first/second latches
    reg v1_second_q;
    reg v2_first_q; // Vector 2 first/second latches
    reg v2_second_q;
    reg [1:0] stk0_q; // Saved flag sets
    reg [1:0] stk1_q;
    reg [1:0] lp_q; // Low-power state
    reg [15:0] stab_q; // Settling counter

    // Two-deep edge store: second edge kept, third lost; set wins
    function [1:0] latch2;
        input first;
        input second;
        input edge_in;
        input clr;
        reg f;
        begin
            f = first & ~clr;
            if (clr)
                f = second;
            latch2 = {f | (edge_in & ~f),
                      (second & ~clr) | (edge_in & f)};
        end
    endfunction

    // Register decode by word index
    function hit;
        input [9:0] a;
        input [7:0] idx;
        begin
            hit = (a[9:2] == idx) && (a[1:0] == 2'b00);
        end
    endfunction

    wire gen = ioc_q[`IOC_GEN];
    wire nmi_fall = nmi_sy_q[2] & ~nmi_sy_q[1];
    wire ab_fall = ab_sy_q[2] & ~ab_sy_q[1];
    wire c_edge = ioc_q[`IOC_POL] ? (~c_sy_q[2] & c_sy_q[1])
                                  : (c_sy_q[2] & ~c_sy_q[1]);

    // Level mode on vector 1 keeps no storage
    wire v1_req = ioc_q[`IOC_LES] ? ~ab_sy_q[1] : v1_first_q;
    wire v2_req = v2_first_q |
        (serial_done_flag & ser_q[`SER_SERIAL_IRQ_ENABLE]);
    wire v3_req = (reload_overflow_flag & rld_q[`RLD_RELOAD_OVERFLOW_IRQ_ENABLE]) |
        (compare_match_flag & rld_q[`RLD_COMPARE_IRQ_ENABLE]) |
        (input_edge_flag & rld_q[`RLD_EIE]);
    wire v4_req = (timer_zero_flag & tsc_q[`TSC_ETI]) |
        (conv_done_flag & conv_q[`CONV_EAI]);
    wire [3:0] mreq = {v4_req, v3_req, v2_req, v1_req} &
        {4{gen}};

    // External-only requests for stop wake
    wire ext_req = gen & (nmi_lat_q | v1_req | v2_first_q);
    wire any_wake = gen & (nmi_lat_q | (|mreq));
    wire pend = nmi_lat_q | (|mreq);

    // Entry choice: NMI over all, maskable only from normal mode
    wire take_nmi = nmi_lat_q & (flag_set != `MODE_NMI);
    wire take_m = (flag_set == `MODE_NORMAL) & (|mreq);
    reg [3:0] onehot;
    reg [11:0] vec_sel;
    always @* begin
        onehot = 4'h0;
        vec_sel = `VEC_4;
        if (mreq[0]) begin
            onehot = 4'h1;
            vec_sel = `VEC_1;
        end else if (mreq[1]) begin
            onehot = 4'h2;
            vec_sel = `VEC_2;
        end else if (mreq[2]) begin
            onehot = 4'h4;
            vec_sel = `VEC_3;
        end else if (mreq[3]) begin
            onehot = 4'h8;
            vec_sel = `VEC_4;
        end
    end

    // Decision points: instruction end, or a completed wake
    wire stab_done = (lp_q == ST_STAB) && (stab_q == 16'h0000);
    wire wake_now = ((lp_q == ST_WAIT) && any_wake) || stab_done;
    wire decide = ((lp_q == ST_RUN) && instr_end) || wake_now;
    wire enter_nmi = decide & take_nmi;
    wire enter_m = decide & ~take_nmi & take_m;
    wire enter = enter_nmi | enter_m;
    wire clr1 = enter_m & onehot[0] & ~ioc_q[`IOC_LES];
    wire clr2 = enter_m & onehot[1];
    wire [1:0] l1 = latch2(v1_first_q, v1_second_q,
                           ab_fall & ~ioc_q[`IOC_LES], clr1);
    wire [1:0] l2 = latch2(v2_first_q, v2_second_q, c_edge, clr2);
    wire sleep_ok = (lp_q == ST_RUN) & ~pend & ~enter;

    // Avalon access qualifiers
    wire acc = (read | write) & ~waitrequest;
    wire wr = write & ~waitrequest & byteenable[0];

    // Synchronisers for asynchronous pins
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_sy_q <= 3'h7;
            ab_sy_q <= 3'h7;
            c_sy_q <= 3'h0;
        end else begin
            nmi_sy_q <= {nmi_sy_q[1:0], nmi_n};
            ab_sy_q <= {ab_sy_q[1:0], port_ab_n};
            c_sy_q <= {c_sy_q[1:0], port_c};
        end
    end

    // Register file; one wait state per access
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ioc_q <= `IOC_RESET;
            tsc_q <= 8'h00;
            conv_q <= 8'h00;
            rld_q <= 8'h00;
            ser_q <= 8'h00;
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            // Release waitrequest for one cycle per request
            waitrequest <= ~((read | write) & waitrequest);
            if (wr && hit(address, `IDX_IOC))
                ioc_q <= writedata[7:0] & 8'h70;
            if (wr && hit(address, `IDX_TSC))
                tsc_q <= writedata[7:0];
            if (wr && hit(address, `IDX_CONV))
                conv_q <= writedata[7:0];
            if (wr && hit(address, `IDX_RLD))
                rld_q <= writedata[7:0];
            if (wr && hit(address, `IDX_SER))
                ser_q <= writedata[7:0];
            if ((read | write) && waitrequest) begin
                // Data readied as waitrequest drops
                readdata <= 32'h00000000;
                if (read && hit(address, `IDX_TSC))
                    readdata <= {24'h000000, tsc_q};
                else if (read && hit(address, `IDX_CONV))
                    readdata <= {24'h000000, conv_q};
                else if (read && hit(address, `IDX_RLD))
                    readdata <= {24'h000000, rld_q};
                else if (read && hit(address, `IDX_SER))
                    readdata <= {24'h000000, ser_q};
                else if (read && hit(address, `IDX_STAT))
                    readdata <= {16'h0000, 4'h0, mreq,
                                 nmi_lat_q, v1_first_q, v2_first_q,
                                 1'b0, lp_q, flag_set};
            end else if (acc) begin
                readdata <= 32'h00000000;
            end
        end
    end

    // Request latches
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_lat_q <= 1'b0;
            v1_first_q <= 1'b0;
            v1_second_q <= 1'b0;
            v2_first_q <= 1'b0;
            v2_second_q <= 1'b0;
        end else begin
            // New edge beats the entry clear
            nmi_lat_q <= nmi_fall | (nmi_lat_q & ~enter_nmi);
            v1_first_q <= l1[1];
            v1_second_q <= l1[0];
            v2_first_q <= l2[1];
            v2_second_q <= l2[0];
        end
    end

    // Flag set tracking, stack of saved sets, core strobes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_set <= `MODE_NORMAL;
            stk0_q <= `MODE_NORMAL;
            stk1_q <= `MODE_NORMAL;
            irq_entry <= 1'b0;
            vector_pc <= 12'h000;
            stack_push <= 1'b0;
            push_pc <= 12'h000;
            stack_pop <= 1'b0;
        end else begin
            irq_entry <= enter;
            stack_push <= enter;
            stack_pop <= return_from_interrupt_exec & ~enter;
            if (enter) begin
                // Save current set, switch to the new one
                flag_set <= enter_nmi ? `MODE_NMI : `MODE_INT;
                stk0_q <= flag_set;
                stk1_q <= stk0_q;
                push_pc <= pc_next;
                vector_pc <= enter_nmi ? `VEC_NMI : vec_sel;
            end else if (return_from_interrupt_exec) begin
                // Restore previous set
                flag_set <= stk0_q;
                stk0_q <= stk1_q;
                stk1_q <= `MODE_NORMAL;
            end
        end
    end

    // Low-power state machine; reset always returns to run
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lp_q <= ST_RUN;
            stab_q <= 16'h0000;
            core_halt <= 1'b0;
            osc_run <= 1'b1;
            core_resume <= 1'b0;
        end else begin
            core_resume <= 1'b0;
            case (lp_q)
                ST_RUN: begin
                    if (stop_exec && sleep_ok && !watchdog_active) begin
                        lp_q <= ST_STOP;
                        core_halt <= 1'b1;
                        osc_run <= 1'b0;
                    end else if ((wait_exec || stop_exec) && sleep_ok) begin
                        lp_q <= ST_WAIT;
                        core_halt <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (any_wake) begin
                        // No settling; clock never stopped
                        lp_q <= ST_RUN;
                        core_halt <= 1'b0;
                        core_resume <= ~enter;
                    end
                end
                ST_STOP: begin
                    if (ext_req) begin
                        lp_q <= ST_STAB;
                        osc_run <= 1'b1;
                        stab_q <= STAB_CYCLES[15:0];
                    end
                end
                ST_STAB: begin
                    if (stab_q == 16'h0000) begin
                        // Entry (main or NMI) or plain resume
                        lp_q <= ST_RUN;
                        core_halt <= 1'b0;
                        core_resume <= ~enter;
                    end else begin
                        stab_q <= stab_q - 16'h0001;
                    end
                end
                default: begin
                    lp_q <= ST_RUN;
                    core_halt <= 1'b0;
                    osc_run <= 1'b1;
                end
            endcase
        end
    end

endmodule // irq_wake_ctrl
`default_nettype wire
